// *** common/buck_ctrl_pkg.sv ***
/*
  Package for the step-down regulator mode and setpoint control block:
  power states, operating modes, setpoint width, debounce timing and the
  packed structs that carry control bits and state.
  Assumes a single 50 MHz clock and a synchronous active-low reset.
*/
`default_nettype none
package buck_ctrl_pkg;
  localparam int unsigned SETPOINT_W   = 6;
  localparam int unsigned CLK_HZ       = 50_000_000;
  // debounce time in microseconds, 8.0 ms
  localparam int unsigned DEBOUNCE_US  = 8_000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DEB_W        = 20;
  localparam logic [5:0]  SETPOINT_RST = 6'h00;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_RUN,
    PWR_STANDBY,
    PWR_SLEEP
  } power_state_t;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_ADAPTIVE,
    MODE_FPWM,
    MODE_LOW_POWER
  } buck_mode_t;

  typedef struct packed {
    logic buck_on;
    logic standby_keep_on;
    logic sleep_keep_on;
    logic low_bias_select;
    logic forced_pwm_select;
  } buck_ctrl_t;

  typedef struct packed {
    logic                  wr_run;
    logic                  wr_standby;
    logic                  wr_sleep;
    logic [SETPOINT_W-1:0] data;
  } setpoint_wr_t;

  typedef struct packed {
    buck_mode_t            mode;
    logic                  switching;
    logic                  discharge;
    logic                  light_load_skip;
    logic                  low_bias;
    logic                  hs_gate_off;
    logic                  ls_gate_off;
    logic                  hs_sense;
    logic                  ls_sense;
    logic                  hs_status;
    logic                  ls_status;
    logic [DEB_W-1:0]      hs_count;
    logic [DEB_W-1:0]      ls_count;
    power_state_t          prev_state;
    logic                  host_released;
    logic                  wr_enable;
    logic [SETPOINT_W-1:0] run_setpoint;
    logic [SETPOINT_W-1:0] standby_setpoint;
    logic [SETPOINT_W-1:0] sleep_setpoint;
    logic [SETPOINT_W-1:0] target;
  } buck_state_t;
endpackage
`default_nettype wire

// *** hw/buck_mode_ctrl.sv ***
/*
  Mode decoding, current-limit debounce and setpoint handling for one
  step-down regulator; instantiate once per regulator.
  Assumes power state, control bits and current-limit comparators are
  synchronous to mclk; the host write port is pre-decoded by the I2C slave.
*/
`default_nettype none
//Contract
// - DCM/CCM follows load; mode also forced by control bits or power state.
// - Every mode available whatever the fused scaling select value.
// - Off mode: stop switching, discharge output through internal resistor.
// - Adaptive is default: fixed frequency at load, pulse skipping light.
// - Disabled if buck_on 0, or keep-on bit 0 in standby/sleep.
// - Enabled, forced PWM 0, low bias 0: adaptive with DCM at light load.
// - In run, low bias never gives low-power operation.
// - Standby/sleep kept on, low bias 1, forced PWM 0: low-power mode.
// - Forced PWM 1 wins over low bias in every state.
// - Forced PWM never falls back to pulse skipping.
// - Switch over current limit is turned off from the cycle after the hit, while it lasts.
// - Limit hit sets sense the next cycle; status after 8.0 ms persistence.
// - Off-to-run start-up copies fused setpoint into all three setpoints.
// - Target is run, standby or sleep setpoint by power state.
// - Fused select 0: setpoints writable after host reset released.
module buck_mode_ctrl #(
  parameter int unsigned DEBOUNCE_CYCLES = buck_ctrl_pkg::DEBOUNCE_CYC
) (
  input  wire logic                                   mclk,
  input  wire logic                                   resetn,
  input  wire buck_ctrl_pkg::power_state_t            power_state,
  input  wire buck_ctrl_pkg::buck_ctrl_t              ctrl,
  input  wire logic                                   light_load,
  input  wire logic                                   hs_limit_hit,
  input  wire logic                                   ls_limit_hit,
  input  wire logic [buck_ctrl_pkg::SETPOINT_W-1:0]   fused_setpoint,
  input  wire logic                                   fused_scaling_select,
  input  wire logic                                   host_reset_out_n,
  input  wire buck_ctrl_pkg::setpoint_wr_t            setpoint_wr,
  output logic [1:0]                                  mode,
  output logic                                        switching,
  output logic                                        discharge,
  output logic                                        light_load_skip,
  output logic                                        low_bias,
  output logic                                        hs_gate_off,
  output logic                                        ls_gate_off,
  output logic                                        hs_limit_sense,
  output logic                                        ls_limit_sense,
  output logic                                        hs_limit_status,
  output logic                                        ls_limit_status,
  output logic                                        setpoint_wr_enable,
  output logic [buck_ctrl_pkg::SETPOINT_W-1:0]        run_setpoint,
  output logic [buck_ctrl_pkg::SETPOINT_W-1:0]        standby_setpoint,
  output logic [buck_ctrl_pkg::SETPOINT_W-1:0]        sleep_setpoint,
  output logic [buck_ctrl_pkg::SETPOINT_W-1:0]        target_setpoint
);
  localparam logic [buck_ctrl_pkg::DEB_W-1:0] DEB_LAST =
    buck_ctrl_pkg::DEB_W'(DEBOUNCE_CYCLES - 1);

  buck_ctrl_pkg::buck_state_t s_q;
  buck_ctrl_pkg::buck_state_t s_d;
  logic                       enabled;
  logic                       in_low;
  logic                       startup;

  always_comb begin
    s_d = s_q;
    in_low = (power_state == buck_ctrl_pkg::PWR_STANDBY) ||
             (power_state == buck_ctrl_pkg::PWR_SLEEP);
    // fused select does not enter the mode decode at all
    enabled = ctrl.buck_on && (power_state != buck_ctrl_pkg::PWR_OFF) &&
              !((power_state == buck_ctrl_pkg::PWR_STANDBY) && !ctrl.standby_keep_on) &&
              !((power_state == buck_ctrl_pkg::PWR_SLEEP) && !ctrl.sleep_keep_on);
    if (!enabled) begin
      s_d.mode = buck_ctrl_pkg::MODE_OFF;
    end else if (ctrl.forced_pwm_select) begin
      s_d.mode = buck_ctrl_pkg::MODE_FPWM;
    end else if (ctrl.low_bias_select && in_low) begin
      s_d.mode = buck_ctrl_pkg::MODE_LOW_POWER;
    end else begin
      s_d.mode = buck_ctrl_pkg::MODE_ADAPTIVE;
    end
    s_d.switching = (s_d.mode != buck_ctrl_pkg::MODE_OFF);
    s_d.discharge = (s_d.mode == buck_ctrl_pkg::MODE_OFF);
    // pulse skipping only from the load level, never in forced PWM
    s_d.light_load_skip = light_load && s_d.switching &&
                          (s_d.mode != buck_ctrl_pkg::MODE_FPWM);
    s_d.low_bias = (s_d.mode == buck_ctrl_pkg::MODE_LOW_POWER);

    s_d.hs_gate_off = hs_limit_hit && s_d.switching;
    s_d.ls_gate_off = ls_limit_hit && s_d.switching;
    s_d.hs_sense = hs_limit_hit;
    s_d.ls_sense = ls_limit_hit;
    // persistence counters; status set once reached, held only while the hit lasts
    // status follows the fault: drops one cycle after the hit goes away
    if (!hs_limit_hit) begin
      s_d.hs_count  = '0;
      s_d.hs_status = 1'b0;
    end else if (s_q.hs_count == DEB_LAST) begin
      s_d.hs_status = 1'b1;
    end else begin
      s_d.hs_count = s_q.hs_count + 1'b1;
    end
    if (!ls_limit_hit) begin
      s_d.ls_count  = '0;
      s_d.ls_status = 1'b0;
    end else if (s_q.ls_count == DEB_LAST) begin
      s_d.ls_status = 1'b1;
    end else begin
      s_d.ls_count = s_q.ls_count + 1'b1;
    end
    s_d.prev_state = power_state;
    startup = (s_q.prev_state == buck_ctrl_pkg::PWR_OFF) &&
              (power_state == buck_ctrl_pkg::PWR_RUN);
    if (power_state == buck_ctrl_pkg::PWR_OFF) begin
      s_d.host_released = 1'b0;
    end else if (host_reset_out_n) begin
      s_d.host_released = 1'b1;
    end
    s_d.wr_enable = s_d.host_released && !fused_scaling_select &&
                    (power_state != buck_ctrl_pkg::PWR_OFF);
    if (startup) begin
      s_d.run_setpoint     = fused_setpoint;
      s_d.standby_setpoint = fused_setpoint;
      s_d.sleep_setpoint   = fused_setpoint;
    end else if (s_q.wr_enable) begin
      if (setpoint_wr.wr_run) begin
        s_d.run_setpoint = setpoint_wr.data;
      end
      if (setpoint_wr.wr_standby) begin
        s_d.standby_setpoint = setpoint_wr.data;
      end
      if (setpoint_wr.wr_sleep) begin
        s_d.sleep_setpoint = setpoint_wr.data;
      end
    end
    unique case (power_state)
      buck_ctrl_pkg::PWR_STANDBY: s_d.target = s_d.standby_setpoint;
      buck_ctrl_pkg::PWR_SLEEP:   s_d.target = s_d.sleep_setpoint;
      default:                    s_d.target = s_d.run_setpoint;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '{mode:             buck_ctrl_pkg::MODE_OFF,
               switching:        1'b0,
               discharge:        1'b1,
               light_load_skip:  1'b0,
               low_bias:         1'b0,
               hs_gate_off:      1'b0,
               ls_gate_off:      1'b0,
               hs_sense:         1'b0,
               ls_sense:         1'b0,
               hs_status:        1'b0,
               ls_status:        1'b0,
               hs_count:         '0,
               ls_count:         '0,
               prev_state:       buck_ctrl_pkg::PWR_OFF,
               host_released:    1'b0,
               wr_enable:        1'b0,
               run_setpoint:     buck_ctrl_pkg::SETPOINT_RST,
               standby_setpoint: buck_ctrl_pkg::SETPOINT_RST,
               sleep_setpoint:   buck_ctrl_pkg::SETPOINT_RST,
               target:           buck_ctrl_pkg::SETPOINT_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign mode               = s_q.mode;
  assign switching          = s_q.switching;
  assign discharge          = s_q.discharge;
  assign light_load_skip    = s_q.light_load_skip;
  assign low_bias           = s_q.low_bias;
  assign hs_gate_off        = s_q.hs_gate_off;
  assign ls_gate_off        = s_q.ls_gate_off;
  assign hs_limit_sense     = s_q.hs_sense;
  assign ls_limit_sense     = s_q.ls_sense;
  assign hs_limit_status    = s_q.hs_status;
  assign ls_limit_status    = s_q.ls_status;
  assign setpoint_wr_enable = s_q.wr_enable;
  assign run_setpoint       = s_q.run_setpoint;
  assign standby_setpoint   = s_q.standby_setpoint;
  assign sleep_setpoint     = s_q.sleep_setpoint;
  assign target_setpoint    = s_q.target;
endmodule
`default_nettype wire

// *** test/buck_ctrl_monitor.sv ***
/*
  Port assertions for buck_mode_ctrl.
  Assumes one clock, mclk, with synchronous active-low resetn.
*/
`default_nettype none
module buck_ctrl_monitor #(parameter int unsigned DEBOUNCE_CYCLES = 16) (
  input wire logic                        mclk, resetn, hs_limit_hit, ls_limit_hit,
  input wire buck_ctrl_pkg::power_state_t power_state,
  input wire buck_ctrl_pkg::buck_ctrl_t   ctrl,
  input wire logic [5:0]                  fused_setpoint, run_setpoint,
  input wire logic [5:0]                  standby_setpoint, sleep_setpoint,
  input wire logic [1:0]                  mode,
  input wire logic                        fused_scaling_select, switching, discharge,
  input wire logic                        light_load_skip, low_bias, ls_gate_off,
  input wire logic                        hs_limit_sense, hs_limit_status, setpoint_wr_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic       on;
  logic [7:0] cnt_q;
  assign on = ctrl.buck_on && power_state != 2'h0 && (power_state != 2'h2 || ctrl.standby_keep_on)
    && (power_state != 2'h3 || ctrl.sleep_keep_on);
  // consecutive hit cycles, saturating
  always_ff @(posedge mclk) cnt_q <= (!resetn || !hs_limit_hit) ? 8'h00 : cnt_q + 8'(cnt_q != 8'hff);
  sequence boot_s;
    power_state == 2'h0 ##1 power_state == 2'h1;
  endsequence
  off_mode_a: assert property (!on |=> mode == 2'h0 && discharge && !switching)
    else $error("regulator not off");
  fpwm_a: assert property (on && ctrl.forced_pwm_select |=> mode == 2'h2 && !low_bias)
    else $error("forced pwm not taken");
  low_pwr_a: assert property (on && power_state[1] && ctrl.low_bias_select
    && !ctrl.forced_pwm_select |=> mode == 2'h3 && low_bias) else $error("low power not taken");
  adaptive_a: assert property (on && !ctrl.forced_pwm_select && !(power_state[1]
    && ctrl.low_bias_select) |=> mode == 2'h1 && switching) else $error("adaptive not taken");
  no_skip_a: assert property (mode == 2'h2 |-> !light_load_skip)
    else $error("skip in forced pwm");
  limit_sense_a: assert property (hs_limit_hit |=> hs_limit_sense) else $error("sense late");
  gate_off_a: assert property (ls_limit_hit && switching |=> ls_gate_off)
    else $error("switch not cut");
  status_on_a: assert property (cnt_q > DEBOUNCE_CYCLES + 1 |-> hs_limit_status)
    else $error("status missing");
  status_early_a: assert property (hs_limit_status |-> cnt_q + 1 >= DEBOUNCE_CYCLES)
    else $error("status early");
  boot_copy_a: assert property (boot_s |=> run_setpoint == $past(fused_setpoint)
    && standby_setpoint == run_setpoint && sleep_setpoint == run_setpoint) else $error("no copy");
  wr_lock_a: assert property (fused_scaling_select |=> !setpoint_wr_enable)
    else $error("writes open");
endmodule
bind buck_mode_ctrl buck_ctrl_monitor #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) mon (.mclk, .resetn,
  .hs_limit_hit, .ls_limit_hit, .power_state, .ctrl, .fused_setpoint, .run_setpoint,
  .standby_setpoint, .sleep_setpoint, .mode, .fused_scaling_select, .switching, .discharge,
  .light_load_skip, .low_bias, .ls_gate_off, .hs_limit_sense, .hs_limit_status,
  .setpoint_wr_enable);
`default_nettype wire

// *** test/host_model.sv ***
/*
  Host-side writer of the setpoint port, one pulse per write while fused select is 0, none while it is 1.
  Assumes the bench calls write() from its negedge-driven sequence.
*/
`default_nettype none
module host_model (
  input  wire logic                  mclk,
  input  wire logic                  fused_scaling_select,
  output var buck_ctrl_pkg::setpoint_wr_t setpoint_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial setpoint_wr = '0;
  task automatic write(input logic [2:0] sel, input logic [5:0] d);
    @(negedge mclk);
    if (!fused_scaling_select) setpoint_wr = {sel, d};
    @(negedge mclk);
    // idle data shows a changed pattern
    setpoint_wr = {3'b000, ~d};
  endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
/*
  Self-checking bench for buck_mode_ctrl with a host writer model.
  Assumes debounce shortened to 16 cycles; inputs change at negedge.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn = 0, light_load = 0, hs_limit_hit = 0, ls_limit_hit = 0;
  logic fused_scaling_select = 0, host_reset_out_n = 0, switching, discharge, light_load_skip;
  logic low_bias, hs_gate_off, ls_gate_off, hs_limit_sense, ls_limit_sense, hs_limit_status;
  logic ls_limit_status, setpoint_wr_enable;
  logic [1:0] mode;
  logic [5:0] fused_setpoint = 6'h00, run_setpoint, standby_setpoint, sleep_setpoint;
  logic [5:0] target_setpoint;
  buck_ctrl_pkg::power_state_t power_state = buck_ctrl_pkg::PWR_OFF;
  buck_ctrl_pkg::buck_ctrl_t   ctrl = '0;
  buck_ctrl_pkg::setpoint_wr_t setpoint_wr;
  int err_count = 0, num_checks = 0, cyc_q = 0;
  buck_mode_ctrl #(.DEBOUNCE_CYCLES(16)) dut (.mclk, .resetn, .power_state, .ctrl, .light_load,
    .hs_limit_hit, .ls_limit_hit, .fused_setpoint, .fused_scaling_select, .host_reset_out_n,
    .setpoint_wr, .mode, .switching, .discharge, .light_load_skip, .low_bias, .hs_gate_off,
    .ls_gate_off, .hs_limit_sense, .ls_limit_sense, .hs_limit_status, .ls_limit_status,
    .setpoint_wr_enable, .run_setpoint, .standby_setpoint, .sleep_setpoint, .target_setpoint);
  host_model host (.mclk, .fused_scaling_select, .setpoint_wr);
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc_q <= cyc_q + 1;
    if (cyc_q == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic setp(input logic [1:0] s);
    power_state = buck_ctrl_pkg::power_state_t'(s);
  endtask
  // {mode, switching, discharge, low_bias, skip}
  function automatic logic [5:0] exp_mode(input logic [1:0] s, input logic [4:0] c);
    logic [1:0] m;
    m = (!c[4] || s == 0 || (s == 2 && !c[3]) || (s == 3 && !c[2])) ? 2'h0
      : c[0] ? 2'h2 : (s[1] && c[1]) ? 2'h3 : 2'h1;
    return {m, m != 0, m == 0, m == 3, c[2] && m != 0 && m != 2};
  endfunction
  task automatic s_boot(input logic sel, input logic [5:0] f);
    resetn = 0;
    setp(0);
    fused_scaling_select = sel;
    fused_setpoint = f;
    host_reset_out_n = 0;
    step(2);
    resetn = 1;
    chk({mode, discharge}, 3'b001);
    setp(1);
    step(2);
    chk({run_setpoint, standby_setpoint, sleep_setpoint, target_setpoint}, {4{f}});
    host_reset_out_n = 1;
    step(3);
    chk(setpoint_wr_enable, !sel);
  endtask
  task automatic s_modes();
    for (int s = 0; s < 4; s++) for (int c = 0; c < 32; c++) begin
      setp(2'(s));
      ctrl = 5'(c);
      light_load = c[2];
      step(1);
      chk({mode, switching, discharge, low_bias, light_load_skip},
          exp_mode(2'(s), 5'(c)));
    end
  endtask
  task automatic s_limit();
    setp(1);
    ctrl = 5'h10;
    step(1);
    hs_limit_hit = 1;
    ls_limit_hit = 1;
    step(1);
    chk({hs_limit_sense, ls_limit_sense, hs_gate_off, ls_gate_off}, 4'hf);
    step(4);
    ls_limit_hit = 0;
    step(6);
    chk({hs_limit_status, ls_limit_status, ls_limit_sense}, 3'b000);
    step(9);
    chk({hs_limit_status, ls_limit_status}, 2'b10);
    hs_limit_hit = 0;
    step(2);
    chk({hs_limit_status, hs_limit_sense}, 2'b00);
  endtask
  task automatic s_write();
    ctrl = 5'h1c;
    host.write(3'b100, 6'h15);
    host.write(3'b010, 6'h2a);
    host.write(3'b001, 6'h3f);
    step(1);
    chk({run_setpoint, standby_setpoint, sleep_setpoint}, {6'h15, 6'h2a, 6'h3f});
    for (int s = 1; s < 4; s++) begin
      setp(2'(s));
      step(2);
      chk(target_setpoint, s == 1 ? 6'h15 : s == 2 ? 6'h2a : 6'h3f);
    end
  endtask
  initial begin
    s_boot(0, 6'h2a);
    s_modes();
    s_limit();
    s_write();
    s_boot(1, 6'h0b);
    s_modes();
    host.write(3'b111, 6'h01);
    step(1);
    chk({run_setpoint, standby_setpoint, sleep_setpoint}, {3{6'h0b}});
    report_and_stop();
  end
endmodule
`default_nettype wire
